// file: rtl/gpio_irq_map.svh
// Register indices, byte addresses, field positions and reset values of the pin interrupt bank.
`ifndef GPIO_IRQ_MAP_SVH
`define GPIO_IRQ_MAP_SVH
`define PIN_COUNT 8
`define IDX_DETECT_ENABLE 32'h1500_10c4
`define IDX_IRQ_PENDING 32'h1500_10c6
`define IDX_TRIGGER_TYPE 32'h1500_10c8
`define IDX_TRIGGER_POLARITY 32'h1500_10ca
`define IDX_EVENT_STATUS 32'h1500_10cc
`define IDX_EVENT_MASK 32'h1500_10ce
`define ADDR_DETECT_ENABLE (`IDX_DETECT_ENABLE * 4)
`define ADDR_IRQ_PENDING (`IDX_IRQ_PENDING * 4)
`define ADDR_TRIGGER_TYPE (`IDX_TRIGGER_TYPE * 4)
`define ADDR_TRIGGER_POLARITY (`IDX_TRIGGER_POLARITY * 4)
`define ADDR_EVENT_STATUS (`IDX_EVENT_STATUS * 4)
`define ADDR_EVENT_MASK (`IDX_EVENT_MASK * 4)
`define FLD_LOW_MSB 7
`define FLD_LOW_LSB 0
`define FLD_BOTH_MSB 15
`define FLD_BOTH_LSB 8
`define RESET_BYTE 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: rtl/gpio_irq_pkg.sv
// Types shared by the pin interrupt bank.
package gpio_irq_pkg;
  typedef enum logic [2:0] {
    SEL_ENABLE,
    SEL_PENDING,
    SEL_TYPE,
    SEL_POLARITY,
    SEL_EVT_STATUS,
    SEL_EVT_MASK,
    SEL_NONE
  } reg_sel_e;
  typedef struct packed {
    logic [7:0] both;
    logic [7:0] pol;
    logic [7:0] typ;
    logic [7:0] en;
  } pin_cfg_s;
endpackage : gpio_irq_pkg

// file: rtl/gpio_bank_irq_detect.sv
// Pin interrupt detection bank with an AXI4-Lite register slave.
//
// Summary of operation
// - Matching pin condition sets its pending flag.
// - Disabled pin never sets pending nor interrupts.
// - Pending read returns one if request occurred.
// - Write one requests clear, zero cancels it.
// - Clear works in edge mode; level self-clears.
// - Reserved upper bits read zero, written zero.
// - Type bit one edge, zero level.
// - Edge mode detects pin transitions as requests.
// - Level mode polarity one high, zero low.
// - Single edge: polarity one rising, zero falling.
// - Both-edges bit effective only in edge mode.
// - Both-edges set makes polarity ignored.
// - Bit zero serves first pin, in order.
// - Enable register bit one enables detection.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "gpio_irq_map.svh"
`default_nettype none
module gpio_bank_irq_detect
  import gpio_irq_pkg::*;
#(
  parameter int PINS = `PIN_COUNT
) (
  input wire logic aclk, // System clock, 200 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [PINS-1:0] pin_in, // Pin levels, bit 0 is the lowest pin.
  output logic pending_any, // High while any pending flag is set.
  output logic irq, // High while an unmasked event bit is set.
  input wire logic [31:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [31:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready // Read data ready.
);

  function automatic reg_sel_e decode(input logic [31:0] addr);
    case (addr)
      32'(`ADDR_DETECT_ENABLE): decode = SEL_ENABLE;
      32'(`ADDR_IRQ_PENDING): decode = SEL_PENDING;
      32'(`ADDR_TRIGGER_TYPE): decode = SEL_TYPE;
      32'(`ADDR_TRIGGER_POLARITY): decode = SEL_POLARITY;
      32'(`ADDR_EVENT_STATUS): decode = SEL_EVT_STATUS;
      32'(`ADDR_EVENT_MASK): decode = SEL_EVT_MASK;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode

  logic [PINS-1:0] sync1_reg, sync2_reg, prev_reg;
  logic [PINS-1:0] pending_reg, pending_next;
  logic [PINS-1:0] clr_req_reg, clr_req_next;
  logic [PINS-1:0] evt_reg, evt_next, evt_mask_reg, evt_mask_next;
  pin_cfg_s cfg_reg, cfg_next;
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [31:0] awaddr_reg, awaddr_next, wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [PINS-1:0] rise, fall, edge_hit, level_hit;
  logic do_write;
  reg_sel_e wsel, rsel;

  // Only the second stage and the previous sample feed the detectors.
  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  always_comb begin
    // Both-edges wins over polarity; otherwise polarity picks the edge.
    edge_hit = (cfg_reg.both & (rise | fall))
             | (~cfg_reg.both & cfg_reg.pol & rise)
             | (~cfg_reg.both & ~cfg_reg.pol & fall);
    // Level mode ignores the both-edges bit and follows polarity only.
    level_hit = (cfg_reg.pol & sync2_reg) | (~cfg_reg.pol & ~sync2_reg);
  end

  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wsel = decode(awaddr_reg);
  assign rsel = decode(s_axi_araddr);

  always_comb begin
    cfg_next = cfg_reg;
    clr_req_next = clr_req_reg;
    evt_mask_next = evt_mask_reg;
    evt_next = evt_reg;
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      // Bit i of every field serves pin i of the bank.
      if (wstrb_reg[0]) begin
        case (wsel)
          SEL_ENABLE: cfg_next.en = wdata_reg[`FLD_LOW_MSB:`FLD_LOW_LSB];
          SEL_PENDING: clr_req_next = wdata_reg[`FLD_LOW_MSB:`FLD_LOW_LSB];
          SEL_TYPE: cfg_next.typ = wdata_reg[`FLD_LOW_MSB:`FLD_LOW_LSB];
          SEL_POLARITY: cfg_next.pol = wdata_reg[`FLD_LOW_MSB:`FLD_LOW_LSB];
          SEL_EVT_MASK: evt_mask_next = wdata_reg[`FLD_LOW_MSB:`FLD_LOW_LSB];
          default: begin
          end
        endcase
      end
      if (wstrb_reg[1] && wsel == SEL_POLARITY) begin
        cfg_next.both = wdata_reg[`FLD_BOTH_MSB:`FLD_BOTH_LSB];
      end
      if (wstrb_reg[0] && wsel == SEL_EVT_STATUS) begin
        evt_next = evt_reg & ~wdata_reg[`FLD_LOW_MSB:`FLD_LOW_LSB];
      end
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = (rsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      rdata_next = 32'h0000_0000;
      case (rsel)
        SEL_ENABLE: rdata_next[`FLD_LOW_MSB:`FLD_LOW_LSB] = cfg_reg.en;
        SEL_PENDING: rdata_next[`FLD_LOW_MSB:`FLD_LOW_LSB] = pending_reg;
        SEL_TYPE: rdata_next[`FLD_LOW_MSB:`FLD_LOW_LSB] = cfg_reg.typ;
        SEL_POLARITY: rdata_next[`FLD_BOTH_MSB:`FLD_LOW_LSB] = {cfg_reg.both, cfg_reg.pol};
        SEL_EVT_STATUS: rdata_next[`FLD_LOW_MSB:`FLD_LOW_LSB] = evt_reg;
        SEL_EVT_MASK: rdata_next[`FLD_LOW_MSB:`FLD_LOW_LSB] = evt_mask_reg;
        default: begin
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    // Edge pins set on a qualified edge and clear on a held clear request;
    // a new edge in the same cycle wins over the clear.
    // Level pins track the source and drop once it goes inactive.
    pending_next = (cfg_reg.typ & ((pending_reg & ~clr_req_reg) | (edge_hit & cfg_reg.en)))
                 | (~cfg_reg.typ & level_hit & (cfg_reg.en | pending_reg));
    // A flag that rises sets its event bit; the set wins over a clear.
    evt_next = evt_next | (pending_next & ~pending_reg);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
      pending_reg <= '0;
      clr_req_reg <= '0;
      evt_reg <= '0;
      evt_mask_reg <= '0;
      cfg_reg <= '0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      pending_reg <= pending_next;
      clr_req_reg <= clr_req_next;
      evt_reg <= evt_next;
      evt_mask_reg <= evt_mask_next;
      cfg_reg <= cfg_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign pending_any = |pending_reg;
  assign irq = |(evt_reg & evt_mask_reg);

  property p_edge_single_sets;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> ((pending_reg & $past(cfg_reg.en & cfg_reg.typ & ~cfg_reg.both
        & ((cfg_reg.pol & rise) | (~cfg_reg.pol & fall))))
        == $past(cfg_reg.en & cfg_reg.typ & ~cfg_reg.both
        & ((cfg_reg.pol & rise) | (~cfg_reg.pol & fall))));
  endproperty
  a_edge_single_sets: assert property (p_edge_single_sets)
    else $error("Qualified single edge did not set pending flag.");

  property p_both_edges_sets;
    @(posedge aclk) disable iff (!aresetn)
      ((cfg_reg.en & cfg_reg.typ & cfg_reg.both & (rise | fall)) != '0)
        |=> ((pending_reg & $past(cfg_reg.en & cfg_reg.typ & cfg_reg.both & (rise | fall)))
        != '0);
  endproperty
  a_both_edges_sets: assert property (p_both_edges_sets)
    else $error("Both-edge request did not set pending flag.");

  property p_disabled_no_set;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> ((pending_reg & ~$past(pending_reg) & ~$past(cfg_reg.en)) == '0);
  endproperty
  a_disabled_no_set: assert property (p_disabled_no_set)
    else $error("Pending flag set on a disabled pin.");

  property p_level_follows;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> ((pending_reg & ~$past(cfg_reg.typ))
        == ($past(level_hit & ~cfg_reg.typ) & ($past(cfg_reg.en) | $past(pending_reg))));
  endproperty
  a_level_follows: assert property (p_level_follows)
    else $error("Level-mode pending flag does not follow its source.");

  property p_edge_clear;
    @(posedge aclk) disable iff (!aresetn)
      ((clr_req_reg & cfg_reg.typ & ~edge_hit) != '0)
        |=> ((pending_reg & $past(clr_req_reg & cfg_reg.typ & ~edge_hit)) == '0);
  endproperty
  a_edge_clear: assert property (p_edge_clear)
    else $error("Clear request failed to clear an edge-mode flag.");

  property p_pending_read;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && rsel == SEL_PENDING)
        |=> (s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(pending_reg)});
  endproperty
  a_pending_read: assert property (p_pending_read)
    else $error("Pending read returned wrong value.");

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> (s_axi_rdata[31:16] == 16'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved read bits not zero.");

  property p_sync_delay;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |-> ##3 (prev_reg == $past(pin_in, 3));
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("Synchroniser delay is not three cycles to previous sample.");

  property p_bank_or;
    @(posedge aclk) disable iff (!aresetn)
      pending_any == (pending_reg != '0);
  endproperty
  a_bank_or: assert property (p_bank_or)
    else $error("Bank output low while a flag is set.");

  property p_irq_gate;
    @(posedge aclk) disable iff (!aresetn)
      ((pending_reg & ~$past(pending_reg) & evt_mask_reg) != '0) |-> irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("Rising pending flag did not raise the interrupt.");

endmodule : gpio_bank_irq_detect
`default_nettype wire

// file: tb/pin_source.sv
// Model of the external levels driven onto the bank's pins.
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input wire logic aclk, // System clock.
  input wire logic [7:0] level_cmd, // Levels the bench asks for.
  output logic [7:0] pin_in // Levels seen by the bank.
);
  initial pin_in = 8'h00;
  // Levels move just after an edge, unrelated to any bus activity.
  always @(posedge aclk) begin
    pin_in <= level_cmd;
  end
endmodule : pin_source
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the pin interrupt bank.
`timescale 1ns/1ps
`include "gpio_irq_map.svh"
`default_nettype none
module tb_top;
  localparam logic [31:0] A_EN = `ADDR_DETECT_ENABLE;
  localparam logic [31:0] A_PD = `ADDR_IRQ_PENDING;
  localparam logic [31:0] A_TY = `ADDR_TRIGGER_TYPE;
  localparam logic [31:0] A_PL = `ADDR_TRIGGER_POLARITY;
  localparam logic [31:0] A_ST = `ADDR_EVENT_STATUS;
  localparam logic [31:0] A_MK = `ADDR_EVENT_MASK;
  logic aclk, aresetn, pending_any, irq;
  logic [7:0] pins, pin_in;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  int mismatches, check_count;
  pin_source ps (.aclk(aclk), .level_cmd(pins), .pin_in(pin_in));
  gpio_bank_irq_detect #(.PINS(8)) uut (.aclk(aclk), .aresetn(aresetn), .pin_in(pin_in),
    .pending_any(pending_any), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Level outputs are looked at mid-cycle, well away from the edge that updates them.
  task automatic chk_pins(input logic exp_irq, input logic exp_any, input string what);
    @(negedge aclk);
    chk(32'({irq, pending_any}), 32'({exp_irq, exp_any}), what);
    @(posedge aclk);
  endtask : chk_pins
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    logic aw, w, b;
    logic [1:0] r;
    n = 0;
    b = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!b && n < 40) begin
      @(negedge aclk);
      aw = awready;
      w = wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
      n++;
    end
    bready <= 1'h0;
    if (!b) begin
      mismatches++;
      $display("BAD t=%0t write answer timed out", $time);
      wrap_up();
    end
    chk(32'(r), 32'(er), "bresp");
    // One idle edge with bready low keeps a following write from driving it twice in one step.
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
    int n;
    logic ar, v;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    v = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!v && n < 40) begin
      @(negedge aclk);
      ar = arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'h0;
      n++;
    end
    rready <= 1'h0;
    if (!v) begin
      mismatches++;
      $display("BAD t=%0t read answer timed out", $time);
      wrap_up();
    end
    chk(d, ed, "rdata");
    chk(32'(r), 32'(er), "rresp");
    // One idle edge with rready low keeps a following read from driving it twice in one step.
    @(posedge aclk);
  endtask : rd
  // Detection latency is three edges; six leaves margin for the pin model's own flop.
  task automatic pinset(input logic [7:0] v);
    pins <= v;
    repeat (6) @(posedge aclk);
  endtask : pinset
  task automatic t_reset;
    rd(A_EN, 32'h0000_0000);
    rd(A_PD, 32'h0000_0000);
    rd(A_TY, 32'h0000_0000);
    rd(A_PL, 32'h0000_0000);
    chk_pins(1'b0, 1'b0, "idle outputs");
    $display("reset test done");
  endtask : t_reset
  task automatic t_reserved;
    wr(A_TY, 32'h0000_00ff);
    rd(A_TY, 32'h0000_00ff);
    wr(A_MK + 32'h0000_0004, 32'h0000_0001, 2'h2);
    rd(A_MK + 32'h0000_0004, 32'h0000_0000, 2'h2);
    $display("reserved test done");
  endtask : t_reserved
  task automatic t_edge;
    wr(A_EN, 32'h0000_00ff);
    wr(A_PL, 32'h0000_0401);
    pinset(8'h07);
    rd(A_PD, 32'h0000_0005);
    pinset(8'h00);
    rd(A_PD, 32'h0000_0007);
    chk_pins(1'b0, 1'b1, "any");
    wr(A_PD, 32'h0000_0007);
    wr(A_PD, 32'h0000_0000);
    rd(A_PD, 32'h0000_0000);
    $display("edge test done");
  endtask : t_edge
  task automatic t_level;
    wr(A_TY, 32'h0000_0000);
    wr(A_PL, 32'h0000_ff10);
    rd(A_PD, 32'h0000_00ef);
    pinset(8'h10);
    rd(A_PD, 32'h0000_00ff);
    wr(A_PD, 32'h0000_00ff);
    wr(A_PD, 32'h0000_0000);
    rd(A_PD, 32'h0000_00ff);
    pinset(8'hef);
    rd(A_PD, 32'h0000_0000);
    $display("level test done");
  endtask : t_level
  task automatic t_disable;
    wr(A_TY, 32'h0000_00ff);
    wr(A_PL, 32'h0000_00ff);
    wr(A_EN, 32'h0000_007f);
    pinset(8'h00);
    pinset(8'h90);
    rd(A_PD, 32'h0000_0010);
    wr(A_PD, 32'h0000_0010);
    wr(A_PD, 32'h0000_0000);
    $display("disable test done");
  endtask : t_disable
  task automatic t_irq;
    wr(A_MK, 32'h0000_0000);
    wr(A_ST, 32'h0000_00ff);
    pinset(8'h00);
    pinset(8'h10);
    rd(A_ST, 32'h0000_0010);
    chk_pins(1'b0, 1'b1, "masked irq");
    wr(A_MK, 32'h0000_0010);
    chk_pins(1'b1, 1'b1, "irq");
    wr(A_ST, 32'h0000_0010);
    chk_pins(1'b0, 1'b1, "cleared irq");
    wr(A_PD, 32'h0000_0010);
    wr(A_PD, 32'h0000_0000);
    chk_pins(1'b0, 1'b0, "flag cleared");
    pinset(8'h00);
    pinset(8'h10);
    chk_pins(1'b1, 1'b1, "re-armed irq");
    $display("irq test done");
  endtask : t_irq
  initial begin
    aresetn = 1'h0;
    pins = 8'h00;
    awaddr = 32'h0000_0000;
    wdata = 32'h0000_0000;
    araddr = 32'h0000_0000;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    mismatches = 0;
    check_count = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_reserved();
    t_edge();
    t_level();
    t_disable();
    t_irq();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
